// File: src/sacs_consts.svh
// Constants for the converter conversion sequencer
`ifndef SACS_CONSTS_SVH
`define SACS_CONSTS_SVH
`define SACS_DIV_CODE_8        2'h0
`define SACS_DIV_CODE_4        2'h1
`define SACS_DIV_CODE_16       2'h2
`define SACS_DIV_CODE_32       2'h3
`define SACS_HALF_DIV_8        5'h04
`define SACS_HALF_DIV_4        5'h02
`define SACS_HALF_DIV_16       5'h08
`define SACS_HALF_DIV_32       5'h10
`define SACS_CONV_CLOCKS       4'hF
`define SACS_TEMP_ACQ_CODE     2'h3
`define SACS_TEMP_CHANNEL      4'h8
`define SACS_CONV_BIT_EXT      0
`define SACS_CONV_BIT_TIMER    1
`define SACS_FIFO_DEPTH        8
`define SACS_CAL_LOAD_CYCLES   8'h10
`define SACS_CAL_COEF_RESET    14'h0000
`endif

// File: src/sacs_pkg.sv
// Types for the converter conversion sequencer
package sacs_pkg;
    typedef enum logic [2:0] {
        SACS_IDLE,
        SACS_SYNC,
        SACS_ACQ,
        SACS_CONV,
        SACS_DONE
    } sacs_state_t;
endpackage : sacs_pkg

// File: src/sacs_fifo.sv
// Result FIFO between the sequencer and the serial shift logic
`timescale 1ns/10ps
module sacs_fifo #(
    parameter int WIDTH = 16,
    parameter int DEPTH = 8
) (
    input  wire logic             sys_clk_i,
    input  wire logic             reset_i,
    input  wire logic             in_valid_i,
    output logic                  in_ready_o,
    input  wire logic [WIDTH-1:0] in_data_i,
    output logic                  out_valid_o,
    input  wire logic             out_ready_i,
    output logic      [WIDTH-1:0] out_data_o
);
    localparam int AW = $clog2(DEPTH);

    if (DEPTH < 2 || (1 << AW) != DEPTH)
    begin : g_bad_depth
        $error("sacs_fifo depth must be a power of two of at least 2");
    end

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW:0]      wr_ptr;
    logic [AW:0]      rd_ptr;
    wire  [AW:0]      fill     = wr_ptr - rd_ptr;
    wire              full     = (fill == (AW+1)'(DEPTH));
    wire              do_write = in_valid_i && !full;
    wire              rd_empty = (fill == '0);
    // Output register refills whenever empty or being drained
    wire              do_read  = !rd_empty && (!out_valid_o || out_ready_i);

    assign in_ready_o = !full;

    always_ff @(posedge sys_clk_i)
    begin
        if (do_write)
            mem[wr_ptr[AW-1:0]] <= in_data_i;
    end

    always_ff @(posedge sys_clk_i)
    begin
        if (reset_i)
        begin
            wr_ptr      <= '0;
            rd_ptr      <= '0;
            out_valid_o <= 1'b0;
            out_data_o  <= '0;
        end
        else
        begin
            if (do_write)
                wr_ptr <= wr_ptr + 1'b1;
            if (do_read)
            begin
                rd_ptr      <= rd_ptr + 1'b1;
                out_data_o  <= mem[rd_ptr[AW-1:0]];
                out_valid_o <= 1'b1;
            end
            else if (out_ready_i)
                out_valid_o <= 1'b0;
        end
    end
endmodule : sacs_fifo

// File: src/sacs_sequencer.sv
// Conversion sequencer: converter clock, trigger handling, results and fast capture
`timescale 1ns/10ps
`include "sacs_consts.svh"

// Operation
// - Converter clock is core clock divided by 8, 4, 16 or 32 by code.
// - Acquisition lasts 1 to 4 converter clocks from a two-bit field.
// - Conversion takes exactly 15 converter clocks after acquisition.
// - Start requests are resynchronised to the converter clock before acquisition.
// - Temperature channel forces divide by 32 and four acquisition clocks.
// - Single-shot does one conversion and self-clears when results update.
// - Continuous bit runs back-to-back conversions until software clears it.
// - Enabled external start pin starts a conversion on its rising edge.
// - Enabled timer overflow starts a conversion on each overflow that arrives while idle.
// - Fast capture bit passes each result to serial logic without core.
// - Fast capture copies high and low result bytes into serial data.
// - Fast capture shifts channel first, then 12-bit result, MSB first.
// - At low rate conversion and transfer finish before next start.
// - At high rate transfer overlaps next conversion and must finish first.
// - Fast capture suspends normal serial and third-port functions.
// - Reset loads factory offset and gain coefficients into calibration registers.
// - Busy flag spans each conversion and the whole calibration load.
module sacs_sequencer #(
    parameter int FIFO_DEPTH = `SACS_FIFO_DEPTH
) (
    input  wire logic        sys_clk_i,
    input  wire logic        reset_i,
    input  wire logic [1:0]  clock_divide_i,
    input  wire logic [1:0]  acquisition_time_i,
    input  wire logic        external_start_enable_i,
    input  wire logic        timer_start_enable_i,
    input  wire logic [3:0]  channel_select_i,
    input  wire logic        single_shot_set_i,
    input  wire logic        continuous_run_request_i,
    input  wire logic        fast_capture_enable_i,
    input  wire logic        external_start_n_i,
    input  wire logic        timer_overflow_i,
    input  wire logic        sar_compare_i,
    input  wire logic [13:0] factory_offset_i,
    input  wire logic [13:0] factory_gain_i,
    input  wire logic        serial_load_ready_i,
    output logic             single_shot_request_o,
    output logic             busy_o,
    output logic             track_o,
    output logic [11:0]      sar_trial_o,
    output logic [7:0]       result_high_byte_o,
    output logic [7:0]       result_low_byte_o,
    output logic             result_update_o,
    output logic [13:0]      offset_coef_o,
    output logic [13:0]      gain_coef_o,
    output logic             fast_capture_mode_o,
    output logic             serial_load_o,
    output logic [15:0]      serial_shift_data_o
);
    if (FIFO_DEPTH < 2)
    begin : g_bad_depth
        $error("sacs_sequencer needs a FIFO of at least two words");
    end

    // Pin synchroniser; first stage read only by second
    logic        ext_meta;
    logic        ext_sync;
    logic        ext_prev;
    logic        tmr_meta;
    logic        tmr_sync;
    logic        tmr_prev;

    // Converter clock
    logic [4:0]  half_cnt;
    logic        cclk;
    logic [1:0]  lat_div;
    logic [1:0]  lat_acq;
    logic        pend;
    logic        run;
    sacs_pkg::sacs_state_t state;
    logic [3:0]  phase_cnt;
    logic [11:0] sar;
    logic [3:0]  conv_chan;
    logic [7:0]  cal_cnt;
    logic        cal_busy;

    wire is_temp = (channel_select_i == `SACS_TEMP_CHANNEL);
    wire [1:0] eff_div = is_temp ? `SACS_DIV_CODE_32 : clock_divide_i;
    wire [1:0] eff_acq = is_temp ? `SACS_TEMP_ACQ_CODE : acquisition_time_i;

    wire [4:0] half_period = (lat_div == `SACS_DIV_CODE_8)  ? `SACS_HALF_DIV_8  :
                             (lat_div == `SACS_DIV_CODE_4)  ? `SACS_HALF_DIV_4  :
                             (lat_div == `SACS_DIV_CODE_16) ? `SACS_HALF_DIV_16 :
                                                              `SACS_HALF_DIV_32;
    // Compare with >= so a switch to a shorter ratio cannot wrap the counter
    wire half_end  = (half_cnt >= half_period - 5'h01);
    wire cclk_fall = half_end && cclk;
    // Converter clock rising edge; sync, acquisition and conversion steps advance only here
    wire cclk_rise = half_end && !cclk;

    // External start on rising edge of the pin
    wire ext_rise  = external_start_enable_i && ext_sync && !ext_prev;
    wire tmr_rise  = timer_start_enable_i && tmr_sync && !tmr_prev;
    wire start_req = ext_rise || tmr_rise || single_shot_set_i
                     || (continuous_run_request_i && state == sacs_pkg::SACS_IDLE && !pend);

    wire fifo_ready;
    wire fifo_valid;
    wire [15:0] fifo_data;
    wire done_now  = (state == sacs_pkg::SACS_DONE);
    wire [15:0] packed_result = {conv_chan, sar[11:8], sar[7:0]};
    // Fast capture path gated by enable
    wire push = done_now && fast_capture_enable_i;

    always_ff @(posedge sys_clk_i)
    begin
        if (reset_i)
        begin
            ext_meta <= 1'b1;
            ext_sync <= 1'b1;
            ext_prev <= 1'b1;
            tmr_meta <= 1'b0;
            tmr_sync <= 1'b0;
            tmr_prev <= 1'b0;
        end
        else
        begin
            ext_meta <= external_start_n_i;
            ext_sync <= ext_meta;
            ext_prev <= ext_sync;
            tmr_meta <= timer_overflow_i;
            tmr_sync <= tmr_meta;
            tmr_prev <= tmr_sync;
        end
    end

    always_ff @(posedge sys_clk_i)
    begin
        if (reset_i)
        begin
            half_cnt <= 5'h00;
            cclk     <= 1'b0;
        end
        else if (half_end)
        begin
            half_cnt <= 5'h00;
            cclk     <= !cclk;
        end
        else
            half_cnt <= half_cnt + 5'h01;
    end

    // Calibration load after reset
    always_ff @(posedge sys_clk_i)
    begin
        if (reset_i)
        begin
            cal_cnt       <= 8'h00;
            cal_busy      <= 1'b1;
            offset_coef_o <= `SACS_CAL_COEF_RESET;
            gain_coef_o   <= `SACS_CAL_COEF_RESET;
        end
        else if (cal_busy)
        begin
            cal_cnt <= cal_cnt + 8'h01;
            if (cal_cnt == `SACS_CAL_LOAD_CYCLES - 8'h01)
            begin
                offset_coef_o <= factory_offset_i;
                gain_coef_o   <= factory_gain_i;
                cal_busy      <= 1'b0;
            end
        end
    end

    always_ff @(posedge sys_clk_i)
    begin
        if (reset_i)
        begin
            state                 <= sacs_pkg::SACS_IDLE;
            pend                  <= 1'b0;
            run                   <= 1'b0;
            lat_div               <= `SACS_DIV_CODE_8;
            lat_acq               <= 2'h0;
            phase_cnt             <= 4'h0;
            sar                   <= 12'h000;
            conv_chan             <= 4'h0;
            single_shot_request_o <= 1'b0;
            result_high_byte_o    <= 8'h00;
            result_low_byte_o     <= 8'h00;
            result_update_o       <= 1'b0;
        end
        else
        begin
            result_update_o <= 1'b0;
            if (single_shot_set_i)
                single_shot_request_o <= 1'b1;
            // Request waits for converter clock edge
            if (start_req && !cal_busy && state == sacs_pkg::SACS_IDLE)
            begin
                state     <= sacs_pkg::SACS_SYNC;
                lat_div   <= eff_div;
                lat_acq   <= eff_acq;
                conv_chan <= channel_select_i;
            end
            // Armed on a fall, so sync spans half to one and a half clocks
            if (cclk_fall && state == sacs_pkg::SACS_SYNC)
                pend <= 1'b1;
            if (cclk_rise)
            begin
                unique case (state)
                    sacs_pkg::SACS_IDLE:
                        phase_cnt <= 4'h0;
                    sacs_pkg::SACS_SYNC:
                        if (pend)
                        begin
                            pend      <= 1'b0;
                            run       <= 1'b1;
                            phase_cnt <= {2'h0, lat_acq};
                            state     <= sacs_pkg::SACS_ACQ;
                        end
                    sacs_pkg::SACS_ACQ:
                        if (phase_cnt == 4'h0)
                        begin
                            phase_cnt <= `SACS_CONV_CLOCKS - 4'h1;
                            sar       <= 12'h800;
                            state     <= sacs_pkg::SACS_CONV;
                        end
                        else
                            phase_cnt <= phase_cnt - 4'h1;
                    sacs_pkg::SACS_CONV:
                        if (phase_cnt == 4'h0)
                            state <= sacs_pkg::SACS_DONE;
                        else
                        begin
                            phase_cnt <= phase_cnt - 4'h1;
                            if (phase_cnt <= 4'hC && phase_cnt != 4'h0)
                            begin
                                sar[phase_cnt - 4'h1] <= sar_compare_i;
                                if (phase_cnt > 4'h1)
                                    sar[phase_cnt - 4'h2] <= 1'b1;
                            end
                        end
                    sacs_pkg::SACS_DONE:
                        state <= sacs_pkg::SACS_DONE;
                endcase
            end
            if (done_now && (fifo_ready || !fast_capture_enable_i))
            begin
                result_high_byte_o    <= packed_result[15:8];
                result_low_byte_o     <= packed_result[7:0];
                result_update_o       <= 1'b1;
                run                   <= 1'b0;
                state                 <= sacs_pkg::SACS_IDLE;
                single_shot_request_o <= 1'b0;
            end
        end
    end

    always_ff @(posedge sys_clk_i)
    begin
        if (reset_i)
        begin
            busy_o              <= 1'b1;
            track_o             <= 1'b0;
            sar_trial_o         <= 12'h000;
            fast_capture_mode_o <= 1'b0;
        end
        else
        begin
            busy_o              <= cal_busy || run;
            track_o             <= (state == sacs_pkg::SACS_ACQ);
            sar_trial_o         <= sar;
            fast_capture_mode_o <= fast_capture_enable_i;
        end
    end

    // Buffer lets transfer overlap next conversion
    sacs_fifo #(
        .WIDTH (16),
        .DEPTH (FIFO_DEPTH)
    ) u_fifo (
        .sys_clk_i   (sys_clk_i),
        .reset_i     (reset_i),
        .in_valid_i  (push),
        .in_ready_o  (fifo_ready),
        .in_data_i   (packed_result),
        .out_valid_o (fifo_valid),
        .out_ready_i (serial_load_ready_i && !serial_load_o),
        .out_data_o  (fifo_data)
    );

    // Copy result bytes into serial data; channel in top bits, MSB first
    always_ff @(posedge sys_clk_i)
    begin
        if (reset_i)
        begin
            serial_load_o       <= 1'b0;
            serial_shift_data_o <= 16'h0000;
        end
        else
        begin
            serial_load_o <= fifo_valid && serial_load_ready_i && !serial_load_o;
            if (fifo_valid && serial_load_ready_i && !serial_load_o)
                serial_shift_data_o <= fifo_data;
        end
    end
endmodule : sacs_sequencer

// File: verif/sacs_properties.sv
// Port-level checks for the conversion sequencer
`timescale 1ns/10ps
module sacs_properties (
    input wire logic       sys_clk_i,
    input wire logic       reset_i,
    input wire logic [1:0] clock_divide_i,
    input wire logic [1:0] acquisition_time_i,
    input wire logic [3:0] channel_select_i,
    input wire logic       serial_load_ready_i,
    input wire logic       single_shot_request_o,
    input wire logic       busy_o,
    input wire logic       track_o,
    input wire logic [7:0] result_high_byte_o,
    input wire logic       result_update_o,
    input wire logic       fast_capture_mode_o,
    input wire logic       serial_load_o
);
    logic       trk_q;
    logic [9:0] trk_len;
    logic [9:0] since_trk;
    logic [4:0] cal_cnt;
    // Temperature channel overrides the programmed timing
    wire        is_temp  = channel_select_i == 4'h8;
    wire  [1:0] acq_code = is_temp ? 2'h3 : acquisition_time_i;
    wire  [9:0] cdiv     = is_temp ? 10'h020 : clock_divide_i == 2'h0 ? 10'h008 :
                           clock_divide_i == 2'h1 ? 10'h004 :
                           clock_divide_i == 2'h2 ? 10'h010 : 10'h020;
    wire  [9:0] acq_len  = ({8'h00, acq_code} + 10'h001) * cdiv;

    // since_trk saturates so a long idle spell cannot wrap into a false pass, and cal_cnt so it cannot wrap into a false fail
    always_ff @(posedge sys_clk_i)
    begin
        trk_q     <= reset_i ? 1'h0 : track_o;
        trk_len   <= reset_i ? 10'h000 : track_o ? (trk_q ? trk_len + 10'h001 : 10'h001) : trk_len;
        since_trk <= (reset_i | track_o) ? 10'h000 : since_trk + {9'h000, since_trk != 10'h3FF};
        cal_cnt   <= reset_i ? 5'h00 : cal_cnt + {4'h0, cal_cnt != 5'h1F};
    end

    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (reset_i);

    sequence s_acq_end;
        $fell(track_o);
    endsequence
    sequence s_fast_word;
        result_update_o && fast_capture_mode_o && serial_load_ready_i;
    endsequence

    chk_single_clear: assert property (result_update_o |=> !single_shot_request_o)
        else $error("single shot bit not cleared after update");
    chk_update_gap: assert property (result_update_o |=> !result_update_o [*8])
        else $error("result update repeated too soon");
    chk_track_busy: assert property (track_o |-> busy_o)
        else $error("tracking without busy");
    chk_acq_length: assert property (s_acq_end |-> trk_len + 10'h001 >= acq_len
        && trk_len <= acq_len + 10'h001)
        else $error("acquisition length wrong");
    chk_conv_length: assert property (result_update_o |-> since_trk >= cdiv * 10'h00F
        && since_trk <= cdiv * 10'h010)
        else $error("conversion length wrong");
    chk_chan_nibble: assert property (result_update_o |-> result_high_byte_o[7:4] == channel_select_i)
        else $error("channel nibble wrong");
    chk_cal_busy: assert property (cal_cnt < 5'h10 |-> busy_o)
        else $error("busy low during calibration load");
    chk_fast_load: assert property (s_fast_word |-> ##[1:8] serial_load_o)
        else $error("fast capture word not handed on");
endmodule : sacs_properties

bind sacs_sequencer sacs_properties u_props (
    .sys_clk_i, .reset_i, .clock_divide_i, .acquisition_time_i, .channel_select_i,
    .serial_load_ready_i, .single_shot_request_o, .busy_o, .track_o,
    .result_high_byte_o, .result_update_o, .fast_capture_mode_o, .serial_load_o);

// File: verif/sacs_far_model.sv
// Far-side model: comparator and serial shift logic
`timescale 1ns/10ps
module sacs_far_model (
    input  wire logic        sys_clk_i,
    input  wire logic [11:0] analog_i,
    input  wire logic [11:0] sar_trial_i,
    input  wire logic        stall_i,
    input  wire logic        serial_load_i,
    input  wire logic [15:0] serial_data_i,
    output logic             sar_compare_o,
    output logic             serial_load_ready_o
);
    logic [15:0] words [$];
    // Trial bit kept while the held input is not below it
    assign sar_compare_o = sar_trial_i <= analog_i;
    // shifter still busy holds off the next word
    assign serial_load_ready_o = !stall_i;
    always @(posedge sys_clk_i)
        if (serial_load_i && serial_load_ready_o)
            words.push_back(serial_data_i);
endmodule : sacs_far_model

// File: verif/sacs_sequencer_tb.sv
// Self-checking bench for the conversion sequencer
`timescale 1ns/10ps
`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin err_total++; \
$display("ERROR t=%0t got=%0h exp=%0h", $time, (g), (e)); end end
module sacs_sequencer_tb;
    logic        clk = 0, rst = 1, ext_en = 0, tmr_en = 0, ss = 0, cont = 0;
    logic        fce = 0, ext_n = 1, tmr = 0, stall = 0;
    logic [1:0]  div = 0, acq = 0;
    logic [3:0]  chan = 0;
    logic [11:0] vin = 0, trial;
    logic        ssr, busy, trk, upd, fcm, sld, srdy, cmp;
    logic [7:0]  rh, rl;
    logic [13:0] oc, gc;
    logic [15:0] sdat;
    int          err_total = 0, n_compared = 0, cyc = 0, lat;
    localparam logic [13:0] ofs_val = 14'h1A5C, gain_val = 14'h0F3B;

    always #2 clk = ~clk;

    sacs_sequencer #(.FIFO_DEPTH(8)) uut (
        .sys_clk_i(clk), .reset_i(rst), .clock_divide_i(div), .acquisition_time_i(acq),
        .external_start_enable_i(ext_en), .timer_start_enable_i(tmr_en),
        .channel_select_i(chan), .single_shot_set_i(ss), .continuous_run_request_i(cont),
        .fast_capture_enable_i(fce), .external_start_n_i(ext_n), .timer_overflow_i(tmr),
        .sar_compare_i(cmp), .factory_offset_i(ofs_val), .factory_gain_i(gain_val),
        .serial_load_ready_i(srdy), .single_shot_request_o(ssr), .busy_o(busy),
        .track_o(trk), .sar_trial_o(trial), .result_high_byte_o(rh), .result_low_byte_o(rl),
        .result_update_o(upd), .offset_coef_o(oc), .gain_coef_o(gc),
        .fast_capture_mode_o(fcm), .serial_load_o(sld), .serial_shift_data_o(sdat));
    sacs_far_model u_far (
        .sys_clk_i(clk), .analog_i(vin), .sar_trial_i(trial), .stall_i(stall),
        .serial_load_i(sld), .serial_data_i(sdat), .sar_compare_o(cmp),
        .serial_load_ready_o(srdy));

    task finish_test;
        $display("Compared %0d, errors %0d", n_compared, err_total);
        if (err_total == 0 && n_compared > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask : finish_test

    always @(posedge clk)
    begin
        cyc++;
        if (cyc == 20000)
        begin
            err_total++;
            finish_test();
        end
    end

    function automatic int dv(input logic [1:0] d, input logic [3:0] c);
        return c == 4'h8 ? 32 : d == 2'h0 ? 8 : d == 2'h1 ? 4 : d == 2'h2 ? 16 : 32;
    endfunction : dv

    function automatic logic [11:0] wv(input int j);
        return 12'h0A5 + 12'(j) * 12'h111;
    endfunction : wv

    task automatic wait_upd(input int lim);
        lat = 0;
        while (upd !== 1'h1 && lat < lim)
        begin
            @(posedge clk);
            lat++;
        end
    endtask : wait_upd

    task automatic conv(input logic [1:0] d, a, input logic [3:0] c, input logic [11:0] v);
        int e;
        int q;
        q = dv(d, c);
        e = q * (c == 4'h8 ? 4 : a + 1);
        @(posedge clk);
        div <= d;
        acq <= a;
        chan <= c;
        vin <= v;
        ss <= 1'h1;
        @(posedge clk);
        ss <= 1'h0;
        @(posedge clk);
        `CHK(ssr, 1'h1)
        wait_upd(2000);
        `CHK(lat > e + 15 * q + q / 2 && lat <= e + 16 * q + q / 2 + 2, 1'h1)
        `CHK({rh, rl}, {c, v})
        @(posedge clk);
        `CHK(ssr, 1'h0)
    endtask : conv

    task automatic t_single;
        for (int d = 0; d < 4; d++)
            conv(2'(d), 2'(d), 4'(d + 1), wv(d + 3));
        conv(2'h1, 2'h0, 4'h8, 12'h3C7);
    endtask : t_single

    task automatic t_cont;
        @(posedge clk);
        div <= 2'h1;
        acq <= 2'h0;
        chan <= 4'h3;
        vin <= 12'h7E1;
        cont <= 1'h1;
        // each result read before the next one lands
        repeat (3)
        begin
            wait_upd(300);
            `CHK({rh, rl}, 16'h37E1)
            @(posedge clk);
        end
        cont <= 1'h0;
        wait_upd(300);
        @(posedge clk);
        wait_upd(300);
        `CHK(upd, 1'h0)
    endtask : t_cont

    task automatic pulse(input bit t);
        @(posedge clk);
        if (t)
            tmr <= 1'h1;
        else
            ext_n <= 1'h0;
        repeat (4) @(posedge clk);
        tmr <= 1'h0;
        ext_n <= 1'h1;
    endtask : pulse

    // one source at a time, pulses spaced beyond a conversion
    task automatic t_trig(input bit t);
        pulse(t);
        wait_upd(200);
        `CHK(upd, 1'h0)
        if (t)
            tmr_en <= 1'h1;
        else
            ext_en <= 1'h1;
        vin <= vin + 12'h101;
        pulse(t);
        wait_upd(300);
        `CHK({rh, rl}, {chan, vin})
        @(posedge clk);
        ext_en <= 1'h0;
        tmr_en <= 1'h0;
    endtask : t_trig

    // serial side stalled and enable set in the same cycle, then triggers, each choosing its mode
    task automatic t_fast;
        @(posedge clk);
        stall <= 1'h1;
        fce <= 1'h1;
        repeat (2) @(posedge clk);
        `CHK(fcm, 1'h1)
        for (int j = 0; j < 8; j++)
            conv(2'h1, 2'h0, 4'(j), wv(j));
        chan <= 4'h8;
        vin <= wv(8);
        ss <= 1'h1;
        @(posedge clk);
        ss <= 1'h0;
        repeat (700) @(posedge clk);
        stall <= 1'h0;
        repeat (100) @(posedge clk);
        `CHK(u_far.words.size(), 9)
        for (int j = 0; j < 9; j++)
            `CHK(u_far.words[j], {4'(j), wv(j)})
        conv(2'h1, 2'h0, 4'h1, 12'h9AB);
        repeat (12) @(posedge clk);
        `CHK(u_far.words[9], 16'h19AB)
        fce <= 1'h0;
        conv(2'h1, 2'h0, 4'h2, 12'h456);
        repeat (20) @(posedge clk);
        `CHK(fcm, 1'h0)
        `CHK(u_far.words.size(), 10)
    endtask : t_fast

    initial
    begin
        repeat (6) @(posedge clk);
        `CHK(busy, 1'h1)
        `CHK(oc, 14'h0000)
        rst <= 1'h0;
        repeat (24) @(posedge clk);
        `CHK({oc, gc}, {ofs_val, gain_val})
        t_single();
        t_cont();
        t_trig(1'b0);
        t_trig(1'b1);
        t_fast();
        finish_test();
    end
endmodule : sacs_sequencer_tb
